// >>> hw/tec_pkg.sv
`default_nettype none

// ==========================================================================
// Shared constants of the receive error counter block.
// ==========================================================================
package tec_pkg;

  // ========================================================================
  // Register map.
  // ========================================================================
  localparam logic [7:0] ERROR_COUNTER_SETUP_OFS       = 8'h41;
  localparam logic [7:0] LINE_VIOLATION_COUNT_HIGH_OFS = 8'h42;
  localparam logic [7:0] LINE_VIOLATION_COUNT_LOW_OFS  = 8'h43;
  localparam logic [7:0] PATH_VIOLATION_COUNT_HIGH_OFS = 8'h44;
  localparam logic [7:0] PATH_VIOLATION_COUNT_LOW_OFS  = 8'h45;
  localparam logic [7:0] SETUP_RESET                   = 8'h00;
  localparam logic [7:0] SETUP_WRITE_MASK              = 8'h7F;
  localparam logic [7:0] UNMAPPED_READ                 = 8'h00;
  localparam logic [15:0] COUNT_RESET                  = 16'h0000;
  localparam logic [15:0] COUNT_MAX                    = 16'hFFFF;

  // ========================================================================
  // Fields of the error counter setup register.
  // ========================================================================
  localparam int EXCESS_ZERO_COUNT_ENABLE_BIT     = 0;
  localparam int OUT_OF_SYNC_COUNTER_FUNCTION_BIT = 1;
  localparam int FS_BIT_ERROR_REPORT_ENABLE_BIT   = 2;
  localparam int E1_VIOLATION_TYPE_SELECT_BIT     = 3;
  localparam int ACCUMULATION_SOURCE_SELECT_BIT   = 4;
  localparam int AUTO_INTERVAL_SELECT_BIT         = 5;
  localparam int MANUAL_COUNT_LATCH_BIT           = 6;

  // ========================================================================
  // Timing.
  // ========================================================================
  localparam int CLK_KHZ            = 40000;
  localparam int ONE_SECOND_MS      = 1000;
  localparam int ONE_SECOND_CYCLES  = ONE_SECOND_MS * CLK_KHZ;
  localparam logic [8:0] T1_SHORT_FRAMES = 9'd333;
  localparam logic [8:0] E1_SHORT_FRAMES = 9'd500;
  localparam logic [4:0] T1_ZERO_RUN       = 5'd16;
  localparam logic [4:0] T1_B8ZS_ZERO_RUN  = 5'd8;

endpackage

`default_nettype wire

// >>> hw/tec_sat_counter.sv
`default_nettype none

// ==========================================================================
// Saturating running counter with a host-visible latched copy.
// ==========================================================================
module tec_sat_counter (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Control.
  input  wire logic        countInc,
  input  wire logic        latchNow,
  // Results.
  output logic [15:0]      runningCount,
  output logic [15:0]      latchedCount
);
  import tec_pkg::*;

  // Running count stops at full scale; on a latch it restarts, keeping a
  // same-cycle event so that none is lost across the boundary.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      runningCount <= COUNT_RESET;
    end else if (latchNow) begin
      runningCount <= {15'h0000, countInc};
    end else if (countInc && runningCount != COUNT_MAX) begin
      runningCount <= runningCount + 16'h0001;
    end
  end

  // Latched copy changes only on an update, never on a read.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      latchedCount <= COUNT_RESET;
    end else if (latchNow) begin
      latchedCount <= runningCount;
    end
  end

  // Saturation hold.
  a_count_saturates: assert property (@(posedge clk) disable iff (sys_rst)
    !$past(latchNow) && $past(runningCount) == COUNT_MAX |-> runningCount == COUNT_MAX)
    else $error("Running count wrapped past full scale.");

endmodule

`default_nettype wire

// >>> hw/tec_error_counters.sv
// Chosen here: the address-and-strobe port.
`default_nettype none

// ==========================================================================
// Receive error counters: line code violations and path errors.
// ==========================================================================
// Summary of operation
// - Counters saturate at maximum, never wrap.
// - Latch each second, or 333/500 frames.
// - Accumulation bit picks automatic or manual update.
// - Manual bit rising latches and clears next cycle.
// - Automatic updates flag the interval timer tick.
// - T1 counts violations plus long zero runs.
// - T1 line counter ignores loss of sync.
// - Function bit selects framing errors or multiframes.
// - E1 type bit picks violations or code violations.
// - E1 violation: equal polarity marks, codewords excluded.
// - E1 code violation: equal polarity violation pair.
// - E1 line counter always counts, holds full.
// - T1 path counts CRC6, Ft, optionally Fs.
// - T1 path counter pauses during sync loss.
// - E1 path counts CRC4, pauses on alignment loss.
// - Counts split high byte low address.
module tec_error_counters #(
  parameter int ONE_SECOND_COUNT = tec_pkg::ONE_SECOND_CYCLES
) (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Register port.
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic [7:0]      regRdData,
  // Framer mode.
  input  wire logic       e1Mode,
  input  wire logic       esfFraming,
  input  wire logic       b8zsEnable,
  input  wire logic       hdb3Enable,
  // Receive line decoder, one bit per strobe.
  input  wire logic       bitStrobe,
  input  wire logic       rxMark,
  input  wire logic       rxPolarity,
  input  wire logic       rxCodeword,
  // Receive framer events.
  input  wire logic       frameStrobe,
  input  wire logic       crc6Error,
  input  wire logic       ftError,
  input  wire logic       fsError,
  input  wire logic       crc4Error,
  input  wire logic       receiveSyncLost,
  input  wire logic       fasSyncLost,
  input  wire logic       crc4SyncLost,
  // Status toward the rest of the framer.
  output logic            intervalTick,
  output logic            outOfSyncCounterFunction,
  output logic            countsUpdated
);
  import tec_pkg::*;

  // ========================================================================
  // Setup register and decoding.
  // ========================================================================
  logic [7:0]  setup_q;
  logic        manualPrev_q;
  logic        manualLatch_q;
  logic        haveMark_q;
  logic        lastMarkPol_q;
  logic        haveViol_q;
  logic        lastViolPol_q;
  logic [4:0]  zeroRun_q;
  logic [8:0]  frameCnt_q;
  logic [25:0] secondCnt_q;
  logic        latchNow;
  logic        autoTick;
  logic        frameWrap;
  logic        secondWrap;
  logic        rawViolation;
  logic        bpvEvent;
  logic        cvEvent;
  logic        zeroRunEvent;
  logic        lineInc;
  logic        pathInc;
  logic [8:0]  frameLimit;
  logic [4:0]  zeroLimit;
  logic [15:0] lineRunning;
  logic [15:0] lineLatched;
  logic [15:0] pathRunning;
  logic [15:0] pathLatched;

  // Returns one field of the setup register.
  function automatic logic setupBit(input logic [7:0] setup, input int pos);
    setupBit = setup[pos];
  endfunction

  // Top bit is kept at zero whatever the host writes.
  // top bit masked
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      setup_q <= SETUP_RESET;
    end else if (regWr && regAddr == ERROR_COUNTER_SETUP_OFS) begin
      setup_q <= regWrData & SETUP_WRITE_MASK;
    end
  end

  assign outOfSyncCounterFunction = setupBit(setup_q, OUT_OF_SYNC_COUNTER_FUNCTION_BIT);

  // ========================================================================
  // Update timing.
  // ========================================================================
  // Edge detector on the manual bit; the latch lands one cycle after the
  // register write that raised it.
  // manual edge latch
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      manualPrev_q  <= 1'b0;
      manualLatch_q <= 1'b0;
    end else begin
      manualPrev_q  <= setupBit(setup_q, MANUAL_COUNT_LATCH_BIT);
      manualLatch_q <= setupBit(setup_q, ACCUMULATION_SOURCE_SELECT_BIT)
                       && setupBit(setup_q, MANUAL_COUNT_LATCH_BIT) && !manualPrev_q;
    end
  end

  assign frameLimit = e1Mode ? E1_SHORT_FRAMES : T1_SHORT_FRAMES;
  assign frameWrap  = frameStrobe && frameCnt_q == frameLimit - 9'd1;
  assign secondWrap = secondCnt_q == 26'(ONE_SECOND_COUNT - 1);

  // Frame counter for the short interval; a mode change may stretch one
  // interval, which is harmless for performance monitoring.
  // short interval frames
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      frameCnt_q <= 9'h000;
    end else if (frameWrap || frameCnt_q >= frameLimit) begin
      frameCnt_q <= 9'h000;
    end else if (frameStrobe) begin
      frameCnt_q <= frameCnt_q + 9'd1;
    end
  end

  // Free-running one-second timer on the system clock.
  // one second timer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      secondCnt_q <= 26'h0000000;
    end else if (secondWrap) begin
      secondCnt_q <= 26'h0000000;
    end else begin
      secondCnt_q <= secondCnt_q + 26'd1;
    end
  end

  assign autoTick = setupBit(setup_q, AUTO_INTERVAL_SELECT_BIT) ? frameWrap : secondWrap;
  assign latchNow = setupBit(setup_q, ACCUMULATION_SOURCE_SELECT_BIT) ? manualLatch_q : autoTick;

  // Tick shown to software only while automatic updates run.
  // timer tick out
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      intervalTick  <= 1'b0;
      countsUpdated <= 1'b0;
    end else begin
      intervalTick  <= autoTick && !setupBit(setup_q, ACCUMULATION_SOURCE_SELECT_BIT);
      countsUpdated <= latchNow;
    end
  end

  // ========================================================================
  // Line code violation detection.
  // ========================================================================
  // A violation is a mark of the same polarity as the previous mark.
  assign rawViolation = bitStrobe && rxMark && haveMark_q && rxPolarity == lastMarkPol_q;

  // Substitution codewords are dropped only when the decoder substitutes.
  // codeword exclusion
  assign bpvEvent = rawViolation && !(rxCodeword && (e1Mode ? hdb3Enable : b8zsEnable));

  assign cvEvent = rawViolation && haveViol_q && rxPolarity == lastViolPol_q;

  // Polarity history of marks and of violations.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      haveMark_q    <= 1'b0;
      lastMarkPol_q <= 1'b0;
      haveViol_q    <= 1'b0;
      lastViolPol_q <= 1'b0;
    end else if (bitStrobe && rxMark) begin
      haveMark_q    <= 1'b1;
      lastMarkPol_q <= rxPolarity;
      if (rawViolation) begin
        haveViol_q    <= 1'b1;
        lastViolPol_q <= rxPolarity;
      end
    end
  end

  // Zero runs count once per run when the run reaches its limit.
  assign zeroLimit    = b8zsEnable ? T1_B8ZS_ZERO_RUN : T1_ZERO_RUN;
  assign zeroRunEvent = bitStrobe && !rxMark && zeroRun_q == zeroLimit - 5'd1;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      zeroRun_q <= 5'h00;
    end else if (bitStrobe && rxMark) begin
      zeroRun_q <= 5'h00;
    end else if (bitStrobe && zeroRun_q < zeroLimit) begin
      zeroRun_q <= zeroRun_q + 5'd1;
    end
  end

  // Line counter ignores every sync indication in both modes.
  // always enabled
  always_comb begin
    if (e1Mode) begin
      lineInc = setupBit(setup_q, E1_VIOLATION_TYPE_SELECT_BIT) ? cvEvent : bpvEvent;
    end else begin
      lineInc = bpvEvent || (setupBit(setup_q, EXCESS_ZERO_COUNT_ENABLE_BIT) && zeroRunEvent);
    end
  end

  // ========================================================================
  // Path error selection.
  // ========================================================================
  always_comb begin
    if (e1Mode) begin
      pathInc = crc4Error && !fasSyncLost && !crc4SyncLost;
    end else if (esfFraming) begin
      pathInc = crc6Error && !receiveSyncLost;
    end else begin
      pathInc = (ftError || (setupBit(setup_q, FS_BIT_ERROR_REPORT_ENABLE_BIT) && fsError))
                && !receiveSyncLost;
    end
  end

  // ========================================================================
  // Counters.
  // ========================================================================
  // saturating counters
  tec_sat_counter lineCounter (
    .clk          (clk),
    .sys_rst      (sys_rst),
    .countInc     (lineInc),
    .latchNow     (latchNow),
    .runningCount (lineRunning),
    .latchedCount (lineLatched)
  );

  tec_sat_counter pathCounter (
    .clk          (clk),
    .sys_rst      (sys_rst),
    .countInc     (pathInc),
    .latchNow     (latchNow),
    .runningCount (pathRunning),
    .latchedCount (pathLatched)
  );

  // ========================================================================
  // Register read port.
  // ========================================================================
  // Read data stand one cycle after the strobe and hold otherwise at zero.
  // high byte first
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      regRdData <= UNMAPPED_READ;
    end else if (regRd) begin
      case (regAddr)
        ERROR_COUNTER_SETUP_OFS:       regRdData <= setup_q;
        LINE_VIOLATION_COUNT_HIGH_OFS: regRdData <= lineLatched[15:8];
        LINE_VIOLATION_COUNT_LOW_OFS:  regRdData <= lineLatched[7:0];
        PATH_VIOLATION_COUNT_HIGH_OFS: regRdData <= pathLatched[15:8];
        PATH_VIOLATION_COUNT_LOW_OFS:  regRdData <= pathLatched[7:0];
        default:                       regRdData <= UNMAPPED_READ;
      endcase
    end else begin
      regRdData <= UNMAPPED_READ;
    end
  end

  // ========================================================================
  // Checks.
  // ========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_manual_latch_next: assert property (
    setup_q[ACCUMULATION_SOURCE_SELECT_BIT] && setup_q[MANUAL_COUNT_LATCH_BIT] && !manualPrev_q
    |=> latchNow ##1 countsUpdated)
    else $error("Manual rising edge did not latch next cycle.");

  a_manual_clears_run: assert property (
    latchNow |=> lineLatched == $past(lineRunning) && lineRunning <= 16'h0001)
    else $error("Latch did not copy and clear the line count.");

  a_auto_source_only: assert property (
    setup_q[ACCUMULATION_SOURCE_SELECT_BIT] && !manualLatch_q |-> !latchNow)
    else $error("Automatic update occurred in manual mode.");

  a_tick_in_auto: assert property (
    intervalTick |-> $past(autoTick) && !$past(setup_q[ACCUMULATION_SOURCE_SELECT_BIT]))
    else $error("Interval tick without an automatic update.");

  a_short_interval: assert property (
    !setup_q[ACCUMULATION_SOURCE_SELECT_BIT] && setup_q[AUTO_INTERVAL_SELECT_BIT] && latchNow
    |-> frameStrobe && frameCnt_q == (e1Mode ? E1_SHORT_FRAMES - 9'h001 : T1_SHORT_FRAMES - 9'h001))
    else $error("Short interval latch at the wrong frame.");

  a_t1_path_paused: assert property (
    !e1Mode && receiveSyncLost |-> !pathInc)
    else $error("T1 path counted during sync loss.");

  a_e1_path_paused: assert property (
    e1Mode && (fasSyncLost || crc4SyncLost) |-> !pathInc)
    else $error("E1 path counted during alignment loss.");

  a_line_ignores_sync: assert property (
    !e1Mode && bpvEvent |-> lineInc)
    else $error("T1 violation not counted.");

  a_read_stable: assert property (
    !latchNow |=> lineLatched == $past(lineLatched) && pathLatched == $past(pathLatched))
    else $error("Latched count changed without an update.");

  a_setup_top_zero: assert property (
    regWr && regAddr == ERROR_COUNTER_SETUP_OFS |=> setup_q == ($past(regWrData) & 8'h7F))
    else $error("Setup write stored the wrong value.");

  a_read_high_byte: assert property (
    regRd && regAddr == LINE_VIOLATION_COUNT_HIGH_OFS && !latchNow
    |=> regRdData == lineLatched[15:8])
    else $error("Line high byte read returned the wrong value.");

endmodule

`default_nettype wire

// >>> test/tec_line_model.sv
`default_nettype none

// ==========================================================================
// Stand-in for the receive line decoder and framer feeding the counters.
// ==========================================================================
module tec_line_model (
  // Clock.
  input  wire logic clk,
  // Line decoder side.
  output var logic  bitStrobe,
  output var logic  rxMark,
  output var logic  rxPolarity,
  output var logic  rxCodeword,
  // Framer side.
  output var logic  frameStrobe,
  output var logic  crc6Error,
  output var logic  ftError,
  output var logic  fsError,
  output var logic  crc4Error
);
  timeunit 1ns;
  timeprecision 1ps;

  // Everything starts idle so the counters see no stray events.
  initial begin
    {bitStrobe, rxMark, rxPolarity, rxCodeword} = 4'h0;
    {frameStrobe, crc6Error, ftError, fsError, crc4Error} = 5'h00;
  end

  // Sends n bits of one kind back to back. Outside a burst the polarity is
  // inverted, so a stale level is never read as a held one.
  task automatic line(input logic m, input logic p, input logic cw, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      {bitStrobe, rxMark, rxPolarity, rxCodeword} <= {1'b1, m, p, cw};
    end
    @(posedge clk);
    {bitStrobe, rxMark, rxPolarity, rxCodeword} <= {2'b00, ~p, 1'b0};
  endtask

  // One cycle of framer error events, ordered crc6, ft, fs, crc4.
  task automatic pulse(input logic [3:0] v);
    @(posedge clk);
    {crc6Error, ftError, fsError, crc4Error} <= v;
    @(posedge clk);
    {crc6Error, ftError, fsError, crc4Error} <= 4'h0;
  endtask

  // Frame boundaries every other cycle.
  task automatic frames(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      frameStrobe <= 1'b1;
      @(posedge clk);
      frameStrobe <= 1'b0;
    end
  endtask
endmodule

`default_nettype wire

// >>> test/tb_tec_error_counters.sv
`default_nettype none

// ==========================================================================
// Compare helper: counts every check and reports each mismatch.
// ==========================================================================
`define TEC_CHK(got, exp) begin checksDone++; if ((got) !== (exp)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end

module tb_tec_error_counters;
  timeunit 1ns;
  timeprecision 1ps;
  import tec_pkg::*;

  // A short second keeps the automatic interval test cheap.
  localparam int SEC = 200;

  typedef struct packed {
    logic        e1, esf, dec;
    logic [7:0]  cfg;
    logic [4:0]  zeros;
    logic [2:0]  sl;
    logic [15:0] lineExp, pathExp;
  } tec_row_t;

  // Mode rows: each sends two violations (one a codeword), a zero run where the row gives one and
  // three of each framer error, then expects the latched counts.
  localparam tec_row_t ROWS [13] = '{
    '{1'b0, 1'b0, 1'b0, 8'h00, 5'd16, 3'b100, 16'h0002, 16'h0000},
    '{1'b0, 1'b0, 1'b0, 8'h01, 5'd16, 3'b000, 16'h0003, 16'h0003},
    '{1'b0, 1'b0, 1'b0, 8'h01, 5'd15, 3'b000, 16'h0002, 16'h0003},
    '{1'b0, 1'b0, 1'b1, 8'h01, 5'd8,  3'b000, 16'h0002, 16'h0003},
    '{1'b0, 1'b0, 1'b1, 8'h00, 5'd8,  3'b000, 16'h0001, 16'h0003},
    '{1'b0, 1'b0, 1'b0, 8'h04, 5'd0,  3'b000, 16'h0002, 16'h0006},
    '{1'b0, 1'b1, 1'b0, 8'h04, 5'd0,  3'b000, 16'h0002, 16'h0003},
    '{1'b0, 1'b1, 1'b0, 8'h02, 5'd0,  3'b000, 16'h0002, 16'h0003},
    '{1'b1, 1'b0, 1'b0, 8'h00, 5'd0,  3'b000, 16'h0002, 16'h0003},
    '{1'b1, 1'b0, 1'b1, 8'h00, 5'd0,  3'b100, 16'h0001, 16'h0003},
    '{1'b1, 1'b0, 1'b1, 8'h08, 5'd0,  3'b010, 16'h0001, 16'h0000},
    '{1'b1, 1'b0, 1'b0, 8'h08, 5'd0,  3'b001, 16'h0001, 16'h0000},
    '{1'b1, 1'b0, 1'b0, 8'h01, 5'd16, 3'b000, 16'h0002, 16'h0003}
  };

  logic       clk = 1'b0;
  logic       sysRst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic       regWr = 1'b0;
  logic       regRd = 1'b0;
  logic [7:0] regRdData;
  logic       e1Mode = 1'b0;
  logic       esfFraming = 1'b0;
  logic       b8zsEnable = 1'b0;
  logic       hdb3Enable = 1'b0;
  logic       receiveSyncLost = 1'b0;
  logic       fasSyncLost = 1'b0;
  logic       crc4SyncLost = 1'b0;
  logic       bitStrobe, rxMark, rxPolarity, rxCodeword, frameStrobe;
  logic       crc6Error, ftError, fsError, crc4Error;
  logic       intervalTick, oosFunc, countsUpdated;
  int         miscompares = 0;
  int         checksDone = 0;
  int         ticks = 0;
  int         updates = 0;

  // Clock at 40 MHz.
  always #12.5 clk = ~clk;

  // Ticks are tallied on the falling edge so the tally never races the bench.
  always @(negedge clk) if (intervalTick === 1'b1) ticks++;

  // Update pulses are tallied the same way, one per latch of either source.
  always @(negedge clk) if (countsUpdated === 1'b1) updates++;

  tec_error_counters #(.ONE_SECOND_COUNT(SEC)) dut_u (
    .clk(clk), .sys_rst(sysRst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .e1Mode(e1Mode), .esfFraming(esfFraming),
    .b8zsEnable(b8zsEnable), .hdb3Enable(hdb3Enable), .bitStrobe(bitStrobe), .rxMark(rxMark),
    .rxPolarity(rxPolarity), .rxCodeword(rxCodeword), .frameStrobe(frameStrobe),
    .crc6Error(crc6Error), .ftError(ftError), .fsError(fsError), .crc4Error(crc4Error),
    .receiveSyncLost(receiveSyncLost), .fasSyncLost(fasSyncLost), .crc4SyncLost(crc4SyncLost),
    .intervalTick(intervalTick), .outOfSyncCounterFunction(oosFunc), .countsUpdated(countsUpdated));

  tec_line_model model_u (
    .clk(clk), .bitStrobe(bitStrobe), .rxMark(rxMark), .rxPolarity(rxPolarity),
    .rxCodeword(rxCodeword), .frameStrobe(frameStrobe), .crc6Error(crc6Error),
    .ftError(ftError), .fsError(fsError), .crc4Error(crc4Error));

  // ========================================================================
  // Register port tasks.
  // ========================================================================
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe; sample it mid-cycle.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    d = regRdData;
  endtask

  task automatic rd16(input logic [7:0] a, output logic [15:0] v);
    rd(a, v[15:8]);
    rd(8'(a + 8'h01), v[7:0]);
  endtask

  // Manual latch, then a settle wait longer than the required minimum.
  task automatic latch(input logic [7:0] cfg);
    int u0;
    u0 = updates;
    wr(ERROR_COUNTER_SETUP_OFS, cfg | 8'h50);
    repeat (4) @(posedge clk);
    `TEC_CHK(updates, u0 + 1)
    wr(ERROR_COUNTER_SETUP_OFS, cfg | 8'h10);
  endtask

  // ========================================================================
  // One mode row: clear, stimulate, latch, read both counts.
  // ========================================================================
  task automatic run(input tec_row_t r);
    logic [15:0] v;
    @(posedge clk);
    e1Mode <= r.e1;
    esfFraming <= r.esf;
    b8zsEnable <= r.dec;
    hdb3Enable <= r.dec;
    {receiveSyncLost, fasSyncLost, crc4SyncLost} <= r.sl;
    wr(ERROR_COUNTER_SETUP_OFS, r.cfg | 8'h10);
    model_u.line(1'b1, 1'b1, 1'b0, 1);
    model_u.line(1'b1, 1'b0, 1'b0, 2);
    latch(r.cfg);
    model_u.line(1'b1, 1'b1, 1'b0, 2);
    model_u.line(1'b1, 1'b1, 1'b1, 1);
    model_u.line(1'b0, 1'b0, 1'b0, int'(r.zeros));
    for (int k = 0; k < 12; k++) model_u.pulse(4'(4'h1 << (k % 4)));
    latch(r.cfg);
    rd16(LINE_VIOLATION_COUNT_HIGH_OFS, v);
    `TEC_CHK(v, r.lineExp)
    rd16(PATH_VIOLATION_COUNT_HIGH_OFS, v);
    `TEC_CHK(v, r.pathExp)
    rd16(LINE_VIOLATION_COUNT_HIGH_OFS, v);
    `TEC_CHK(v, r.lineExp)
  endtask

  task automatic finish_test();
    $display("TB: checks=%0d mismatches=%0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ========================================================================
  // Main sequence.
  // ========================================================================
  initial begin
    logic [7:0]  b;
    logic [15:0] v;
    int          t0;
    repeat (20) @(posedge clk);
    sysRst <= 1'b0;
    for (int a = 8'h40; a <= 8'h46; a++) begin
      rd(8'(a), b);
      `TEC_CHK(b, 8'h00)
    end
    wr(ERROR_COUNTER_SETUP_OFS, 8'hFF);
    rd(ERROR_COUNTER_SETUP_OFS, b);
    `TEC_CHK(b, 8'h7F)
    `TEC_CHK(oosFunc, 1'b1)
    wr(LINE_VIOLATION_COUNT_HIGH_OFS, 8'hAA);
    rd(LINE_VIOLATION_COUNT_HIGH_OFS, b);
    `TEC_CHK(b, 8'h00)
    wr(ERROR_COUNTER_SETUP_OFS, 8'h10);
    @(negedge clk);
    `TEC_CHK(oosFunc, 1'b0)
    $display("TEST registers done");
    repeat (4) @(posedge clk);
    t0 = ticks;
    foreach (ROWS[i]) run(ROWS[i]);
    `TEC_CHK(ticks, t0)
    $display("TEST modes done");
    @(posedge clk);
    e1Mode <= 1'b0;
    wr(ERROR_COUNTER_SETUP_OFS, 8'h20);
    t0 = ticks;
    model_u.frames(332);
    `TEC_CHK(ticks, t0)
    model_u.frames(1);
    repeat (4) @(posedge clk);
    `TEC_CHK(ticks, t0 + 1)
    e1Mode <= 1'b1;
    model_u.frames(499);
    `TEC_CHK(ticks, t0 + 1)
    model_u.frames(1);
    repeat (4) @(posedge clk);
    `TEC_CHK(ticks, t0 + 2)
    wr(ERROR_COUNTER_SETUP_OFS, 8'h00);
    t0 = ticks;
    for (int i = 0; i < 2 * SEC && ticks == t0; i++) @(posedge clk);
    t0 = ticks;
    repeat (SEC - 1) @(posedge clk);
    `TEC_CHK(ticks, t0)
    @(posedge clk);
    `TEC_CHK(ticks, t0 + 1)
    $display("TEST intervals done");
    wr(ERROR_COUNTER_SETUP_OFS, 8'h10);
    model_u.line(1'b1, 1'b1, 1'b0, 65537);
    latch(8'h00);
    rd16(LINE_VIOLATION_COUNT_HIGH_OFS, v);
    `TEC_CHK(v, COUNT_MAX)
    $display("TEST saturation done");
    finish_test();
  end

  // Watchdog: the sequence needs about 70000 cycles, most of them the
  // saturation burst, so this leaves margin without a long hang.
  initial begin
    repeat (90000) @(posedge clk);
    miscompares++;
    finish_test();
  end
endmodule

`default_nettype wire
